// *** src/adp_pkg.sv ***
package adp_pkg;
    // register word indices; byte address is index times four
    localparam logic [6:0] IDX_SCFG = 7'h00;
    localparam logic [6:0] IDX_CTRL = 7'h01;
    localparam logic [6:0] IDX_STAT = 7'h02;
    localparam logic [6:0] IDX_IRQS = 7'h03;
    localparam logic [6:0] IDX_IRQM = 7'h04;
    localparam int FOUR_WIRE_BIT = 16;
    // control register fields
    localparam int CTRL_W = 4;
    localparam int CTRL_PD = 0;
    localparam int CTRL_EDGE = 1;
    localparam int CTRL_SYNC_DIS = 2;
    localparam int CTRL_OVR_SYNC = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    // status and interrupt fields
    localparam int IRQ_W = 3;
    localparam int IRQ_SYNC = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_SER = 2;
    localparam int ST_PD = 0;
    localparam int ST_RUN = 1;
    localparam int ST_OVR = 2;
    // output clock: four core cycles, one data word per half
    localparam logic [1:0] PH_LOAD0 = 2'h0;
    localparam logic [1:0] PH_EDGE0 = 2'h1;
    localparam logic [1:0] PH_LOAD1 = 2'h2;
    localparam logic [1:0] PH_EDGE1 = 2'h3;
    localparam logic [3:0] SYNC_LAST = 4'hF;
    localparam int SAMPLE_W = 12;
    // serial frame: read flag, 7-bit index, 24 data bits, msb first
    localparam int SER_AW = 7;
    localparam int SER_DW = 24;
    localparam logic [5:0] HDR_LAST = 6'h07;
    localparam logic [5:0] FRAME_LAST = 6'h1F;
    // synchronised pin vector positions
    localparam int PIN_W = 5;
    localparam int PIN_SYNC = 0;
    localparam int PIN_EN = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_SDI = 3;
    localparam int PIN_SEL = 4;
    typedef enum logic [2:0] {
        ADP_S_IDLE = 3'h1,
        ADP_S_HDR = 3'h2,
        ADP_S_DAT = 3'h4
    } adp_ser_st_t;
endpackage

// *** src/adp_serial_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface adp_serial_if;
    logic sclk;
    logic sdi;
    logic sel;
    logic four;
    logic wr;
    logic [adp_pkg::SER_AW-1:0] addr;
    logic [adp_pkg::SER_DW-1:0] wdata;
    logic [adp_pkg::SER_DW-1:0] rdata;
    logic sdio_out;
    logic sdio_oe_b;
    logic sdo_out;
    logic sdo_oe_b;
    modport port(input sclk, sdi, sel, four, rdata,
        output wr, addr, wdata, sdio_out, sdio_oe_b, sdo_out, sdo_oe_b);
    modport core(output sclk, sdi, sel, four, rdata,
        input wr, addr, wdata, sdio_out, sdio_oe_b, sdo_out, sdo_oe_b);
endinterface
`default_nettype wire

// *** src/adp_serial.sv ***
`timescale 1ns/10ps
`default_nettype none
module adp_serial (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // towards the register core
    adp_serial_if.port sif
);
    import adp_pkg::*;

    typedef struct packed {
        adp_ser_st_t st;
        logic [5:0] cnt;
        logic [SER_DW-1:0] sh;
        logic [SER_DW-1:0] out_sh;
        logic rw;
        logic [SER_AW-1:0] addr;
        logic ld;
        logic wr;
        logic sclk_prev;
        logic sdio_out;
        logic sdio_oe_b;
        logic sdo_out;
        logic sdo_oe_b;
    } adp_ser_t;

    adp_ser_t q;
    adp_ser_t d;
    logic rise;
    logic fall;

    assign sif.wr = q.wr;
    assign sif.addr = q.addr;
    assign sif.wdata = q.sh;
    assign sif.sdio_out = q.sdio_out;
    assign sif.sdio_oe_b = q.sdio_oe_b;
    assign sif.sdo_out = q.sdo_out;
    assign sif.sdo_oe_b = q.sdo_oe_b;

    always_comb begin
        rise = sif.sclk & ~q.sclk_prev;
        fall = ~sif.sclk & q.sclk_prev;
        d = q;
        d.sclk_prev = sif.sclk;
        d.wr = 1'b0;
        d.ld = 1'b0;
        if (!sif.sel) begin
            d.st = ADP_S_IDLE;
            d.cnt = 6'h00;
            d.sdio_oe_b = 1'b1;
            d.sdo_oe_b = 1'b1;
        end else begin
            unique case (q.st)
                ADP_S_IDLE, ADP_S_HDR: begin
                    if (rise) begin
                        d.sh = {q.sh[SER_DW-2:0], sif.sdi};
                        d.cnt = q.cnt + 6'h01;
                        d.st = ADP_S_HDR;
                        if (q.cnt == HDR_LAST) begin
                            d.st = ADP_S_DAT;
                            d.rw = q.sh[SER_AW-1];
                            d.addr = {q.sh[SER_AW-2:0], sif.sdi};
                            d.ld = 1'b1;
                        end
                    end
                end
                ADP_S_DAT: begin
                    if (q.ld) begin
                        d.out_sh = sif.rdata;
                    end
                    if (rise) begin
                        d.sh = {q.sh[SER_DW-2:0], sif.sdi};
                        d.cnt = q.cnt + 6'h01;
                        if (q.cnt == FRAME_LAST) begin
                            d.st = ADP_S_IDLE;
                            d.cnt = 6'h00;
                            d.wr = ~q.rw;
                        end
                    end
                    // read data leaves on falling serial clock edges
                    if (fall && q.rw && !q.ld) begin
                        d.out_sh = {q.out_sh[SER_DW-2:0], 1'b0};
                        if (sif.four) begin
                            d.sdo_out = q.out_sh[SER_DW-1];
                            d.sdo_oe_b = 1'b0;
                        end else begin
                            d.sdio_out = q.out_sh[SER_DW-1];
                            d.sdio_oe_b = 1'b0;
                        end
                    end
                end
                default: d.st = ADP_S_IDLE;
            endcase
        end
        if (sif.four) begin
            d.sdio_oe_b = 1'b1;
        end else begin
            d.sdo_oe_b = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: ADP_S_IDLE, sdio_oe_b: 1'b1, sdo_oe_b: 1'b1,
                default: '0};
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// *** src/adp_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module adp_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins
    input wire logic sync_input,
    input wire logic chip_enable,
    input wire logic serial_port_reset_n,
    // serial port pins
    input wire logic serial_clk,
    input wire logic serial_port_select,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_b,
    output logic serial_read_line,
    output logic serial_read_line_oe_b,
    // converter core
    input wire logic [adp_pkg::SAMPLE_W-1:0] core_sample,
    input wire logic core_overrange,
    // sample output pins
    output logic [adp_pkg::SAMPLE_W-1:0] sample_data_bus,
    output logic data_output_clock,
    output logic sync_output,
    output logic overrange_flag,
    output logic power_down,
    output logic irq
);
    import adp_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] pins_m;
        logic [PIN_W-1:0] pins_s;
        logic sync_prev;
        logic [1:0] phase;
        logic dclk;
        logic [SAMPLE_W-1:0] data;
        logic ovr;
        logic ovr_pin;
        logic sync_run;
        logic [3:0] sync_cnt;
        logic sync_out;
        logic pd;
        logic cfg_four;
        logic [CTRL_W-1:0] ctrl;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } adp_state_t;

    adp_state_t q;
    adp_state_t d;
    logic [PIN_W-1:0] pin_raw;
    logic [1:0] rs_q;
    logic cfg_rst_b;
    logic srst_raw_b;
    logic sync_rise;
    logic [6:0] apb_idx;
    logic apb_ok;
    adp_serial_if sif();

    ////////////////////////////////////////////////////////////////////////
    // reset: the serial reset pin clears state at once, release is timed
    assign srst_raw_b = rst_b & serial_port_reset_n;
    always_ff @(posedge core_clk or negedge srst_raw_b) begin
        if (!srst_raw_b) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign cfg_rst_b = rs_q[1];

    ////////////////////////////////////////////////////////////////////////
    // pins and serial port
    assign pin_raw[PIN_SYNC] = sync_input;
    assign pin_raw[PIN_EN] = chip_enable;
    assign pin_raw[PIN_SCLK] = serial_clk;
    assign pin_raw[PIN_SDI] = sdio_in;
    assign pin_raw[PIN_SEL] = serial_port_select;
    assign sif.sclk = q.pins_s[PIN_SCLK];
    assign sif.sdi = q.pins_s[PIN_SDI];
    assign sif.sel = q.pins_s[PIN_SEL];
    assign sif.four = q.cfg_four;
    assign sif.rdata = SER_DW'(rd_reg(q, sif.addr));

    adp_serial u_serial (
        .core_clk(core_clk),
        .rst_b(cfg_rst_b),
        .sif(sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file
    function automatic logic [31:0] rd_reg(adp_state_t s, logic [6:0] i);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (i)
            IDX_SCFG: v[FOUR_WIRE_BIT] = s.cfg_four;
            IDX_CTRL: v[CTRL_W-1:0] = s.ctrl;
            IDX_STAT: v[ST_OVR:ST_PD] = {s.ovr, s.sync_run, s.pd};
            IDX_IRQS: v[IRQ_W-1:0] = s.irq_stat;
            IDX_IRQM: v[IRQ_W-1:0] = s.irq_mask;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic adp_state_t wr_reg(adp_state_t s, logic [6:0] i,
        logic [31:0] v);
        adp_state_t r;
        r = s;
        if (i == IDX_SCFG) r.cfg_four = v[FOUR_WIRE_BIT];
        if (i == IDX_CTRL) r.ctrl = v[CTRL_W-1:0];
        if (i == IDX_IRQS) r.irq_stat = s.irq_stat & ~v[IRQ_W-1:0];
        if (i == IDX_IRQM) r.irq_mask = v[IRQ_W-1:0];
        return r;
    endfunction

    assign apb_idx = {1'b0, paddr[7:2]};
    assign apb_ok = (paddr[1:0] == 2'h0) && (apb_idx <= IDX_IRQM);
    assign sync_rise = q.pins_s[PIN_SYNC] & ~q.sync_prev;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        d.pins_m = pin_raw;
        d.pins_s = q.pins_m;
        d.sync_prev = q.pins_s[PIN_SYNC];
        // apb: answer in the second access cycle
        d.pready = 1'b0;
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = ~apb_ok;
            d.prdata = (apb_ok && !pwrite) ? rd_reg(q, apb_idx) : '0;
        end
        if (psel && penable && q.pready && pwrite && apb_ok) begin
            d = wr_reg(d, apb_idx, pwdata);
        end
        if (sif.wr) begin
            d = wr_reg(d, sif.addr, {8'h00, sif.wdata});
        end
        d.pd = ~q.pins_s[PIN_EN] | q.ctrl[CTRL_PD];
        // sample path and forwarded clock
        if (sync_rise) begin
            d.phase = PH_LOAD0;
            d.dclk = q.ctrl[CTRL_EDGE];
            d.data = '0;
            d.ovr = 1'b0;
            d.sync_cnt = 4'h0;
            d.sync_run = 1'b1;
        end else if (d.pd) begin
            d.phase = PH_LOAD0;
            d.data = '0;
            d.ovr = 1'b0;
        end else begin
            d.phase = q.phase + 2'h1;
            unique case (q.phase)
                PH_LOAD0, PH_LOAD1: begin
                    d.data = core_sample;
                    d.ovr = core_overrange;
                end
                PH_EDGE0: d.dclk = ~q.ctrl[CTRL_EDGE];
                PH_EDGE1: begin
                    d.dclk = q.ctrl[CTRL_EDGE];
                    d.sync_cnt = q.sync_cnt + 4'h1;
                end
            endcase
        end
        d.sync_out = q.sync_run & ~q.ctrl[CTRL_SYNC_DIS]
            & (d.sync_cnt == SYNC_LAST);
        d.ovr_pin = q.ctrl[CTRL_OVR_SYNC] ? d.sync_out : d.ovr;
        // sticky events: a set in the clearing cycle wins
        if (sync_rise) d.irq_stat[IRQ_SYNC] = 1'b1;
        if (d.ovr && !q.ovr) d.irq_stat[IRQ_OVR] = 1'b1;
        if (sif.wr) d.irq_stat[IRQ_SER] = 1'b1;
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge core_clk or negedge cfg_rst_b) begin
        if (!cfg_rst_b) begin
            // enable pin idles high: no power-down blip after release
            q <= '{ctrl: CTRL_RST, pins_m: PIN_W'(1'b1) << PIN_EN,
                pins_s: PIN_W'(1'b1) << PIN_EN, default: '0};
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign sdio_out = sif.sdio_out;
    assign sdio_oe_b = sif.sdio_oe_b;
    assign serial_read_line = sif.sdo_out;
    assign serial_read_line_oe_b = sif.sdo_oe_b;
    assign sample_data_bus = q.data;
    assign data_output_clock = q.dclk;
    assign sync_output = q.sync_out;
    assign overrange_flag = q.ovr_pin;
    assign power_down = q.pd;
    assign irq = q.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!cfg_rst_b);

    sequence s_sync_rise;
        q.pins_s[PIN_SYNC] && !q.sync_prev;
    endsequence
    sequence s_running;
        !d.pd && !sync_rise;
    endsequence

    property p_sync_low_idle;
        $rose(q.irq_stat[IRQ_SYNC]) |-> $past(q.pins_s[PIN_SYNC]);
    endproperty
    a_sync_low_idle: assert property (p_sync_low_idle)
        else $error("sync event without a high sync input");

    property p_sync_reset;
        s_sync_rise |=> q.phase == PH_LOAD0 && q.data == '0 && q.sync_run;
    endproperty
    a_sync_reset: assert property (p_sync_reset)
        else $error("sync capture did not reset the output logic");

    property p_power_down;
        (!q.pins_s[PIN_EN] || q.ctrl[CTRL_PD]) && !sync_rise
            |=> q.pd && q.data == '0;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down not applied");

    property p_three_wire_quiet;
        !q.cfg_four && !$past(q.cfg_four) |-> serial_read_line_oe_b;
    endproperty
    a_three_wire_quiet: assert property (p_three_wire_quiet)
        else $error("read line driven in three-wire mode");

    property p_four_wire_input;
        q.cfg_four && $past(q.cfg_four) |-> sdio_oe_b;
    endproperty
    a_four_wire_input: assert property (p_four_wire_input)
        else $error("data line driven in four-wire mode");

    property p_sample_load;
        s_running ##0 (q.phase == PH_LOAD0 || q.phase == PH_LOAD1)
            |=> q.data == $past(core_sample) && q.ovr == $past(core_overrange);
    endproperty
    a_sample_load: assert property (p_sample_load)
        else $error("sample not presented on the bus");

    property p_centre_edge;
        s_running ##0 q.phase == PH_EDGE0
            |=> q.dclk != $past(q.ctrl[CTRL_EDGE])
            ##2 q.dclk == $past(q.ctrl[CTRL_EDGE]) || q.pd;
    endproperty
    a_centre_edge: assert property (p_centre_edge)
        else $error("data clock edge misplaced");

    property p_sync_disable;
        q.ctrl[CTRL_SYNC_DIS] |=> !q.sync_out;
    endproperty
    a_sync_disable: assert property (p_sync_disable)
        else $error("sync output active while disabled");

    property p_ovr_mux;
        q.ovr_pin == (q.ctrl[CTRL_OVR_SYNC] ? q.sync_out : q.ovr)
            || $changed(q.ctrl);
    endproperty
    a_ovr_mux: assert property (p_ovr_mux)
        else $error("overrange pin carries the wrong signal");
endmodule
`default_nettype wire

// *** test/adp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module adp_host_model (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic serial_clk,
    output logic serial_port_select,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_b,
    input wire logic serial_read_line,
    input wire logic serial_read_line_oe_b,
    // sample pins
    input wire logic [adp_pkg::SAMPLE_W-1:0] sample_data_bus,
    input wire logic data_output_clock
);
    import adp_pkg::*;
    logic drv_q = 1'b0;
    logic bit_q = 1'b0;
    logic four_q = 1'b0;
    int bad_q = 0;
    int ecnt_q = 0;
    logic [SAMPLE_W-1:0] cap_q = '0;
    initial begin
        serial_clk = 1'b0;
        serial_port_select = 1'b0;
    end
    // wire level: device, else host, else pull-down
    assign sdio_in = (sdio_oe_b === 1'b0) ? sdio_out : (drv_q & bit_q);
    // the pin of the unused mode must stay released
    always @(posedge core_clk) begin
        if (serial_port_select && (four_q ? sdio_oe_b === 1'b0
            : serial_read_line_oe_b === 1'b0)) begin
            bad_q++;
        end
    end
    // receiver takes a word on each output clock edge
    always @(data_output_clock) begin
        cap_q = sample_data_bus;
        ecnt_q++;
    end
    task automatic xfer(input logic rd, input logic [6:0] idx,
        input logic [23:0] d, input logic four, output logic [23:0] q);
        logic [31:0] f;
        f = {rd, idx, d};
        q = '0;
        four_q = four;
        serial_port_select <= 1'b1;
        for (int i = 31; i >= 0; i--) begin
            drv_q <= !(rd && i < 24);
            bit_q <= f[i];
            repeat (6) @(posedge core_clk);
            serial_clk <= 1'b1;
            if (i < 24) begin
                q[i] = four ? (serial_read_line_oe_b === 1'b0
                    && serial_read_line) : sdio_in;
            end
            repeat (6) @(posedge core_clk);
            serial_clk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        serial_port_select <= 1'b0;
        drv_q <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// *** test/adc_digital_pin_interface_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_digital_pin_interface_tb_top;
    import adp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sync_input = 1'b0;
    logic chip_enable = 1'b1;
    logic serial_port_reset_n = 1'b1;
    logic serial_clk;
    logic serial_port_select;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe_b;
    logic serial_read_line;
    logic serial_read_line_oe_b;
    logic [SAMPLE_W-1:0] core_sample = '0;
    logic core_overrange = 1'b0;
    logic [SAMPLE_W-1:0] sample_data_bus;
    logic data_output_clock;
    logic sync_output;
    logic overrange_flag;
    logic power_down;
    logic irq;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    always #50 core_clk = ~core_clk;
    adp_top adp_top_inst (.core_clk(core_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_input(sync_input),
        .chip_enable(chip_enable),
        .serial_port_reset_n(serial_port_reset_n),
        .serial_clk(serial_clk), .serial_port_select(serial_port_select),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b),
        .serial_read_line(serial_read_line),
        .serial_read_line_oe_b(serial_read_line_oe_b),
        .core_sample(core_sample), .core_overrange(core_overrange),
        .sample_data_bus(sample_data_bus),
        .data_output_clock(data_output_clock), .sync_output(sync_output),
        .overrange_flag(overrange_flag), .power_down(power_down),
        .irq(irq));
    adp_host_model adp_host_model_inst (.core_clk(core_clk),
        .serial_clk(serial_clk), .serial_port_select(serial_port_select),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b),
        .serial_read_line(serial_read_line),
        .serial_read_line_oe_b(serial_read_line_oe_b),
        .sample_data_bus(sample_data_bus),
        .data_output_clock(data_output_clock));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rd_exp(input logic [6:0] i,
        input logic [31:0] w);
        case (i)
            IDX_SCFG: return w & (32'h1 << FOUR_WIRE_BIT);
            IDX_CTRL: return w & ((32'h1 << CTRL_W) - 32'h1);
            IDX_IRQM: return w & ((32'h1 << IRQ_W) - 32'h1);
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic exp_irq(input logic [31:0] s, m);
        return |(s & m);
    endfunction
    task summarize;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk_word(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task chk_bit(input logic got, exp, input string m);
        chk_word({31'h0, got}, {31'h0, exp}, m);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [6:0] i, output logic [31:0] r);
        logic e;
        apb(1'b0, 8'({i, 2'b00}), 32'h0, r, e);
    endtask
    task wr(input logic [6:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, 8'({i, 2'b00}), d, r, e);
    endtask
    task wait_pin(input int p, lim, output logic seen, lev);
        logic x;
        seen = 1'b0;
        lev = 1'b0;
        for (int n = 0; n < lim && !seen; n++) begin
            @(posedge core_clk);
            x = p == 0 ? sync_output : p == 1 ? overrange_flag : power_down;
            if (x === 1'b1) begin
                seen = 1'b1;
                lev = data_output_clock;
            end
        end
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 12000) begin
            error_cnt++;
            $display("FAIL %0t timeout", $time);
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r, v;
        logic e, s, l0, l1;
        logic [23:0] q;
        int n;
        void'($urandom(53));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int k = 0; k < 5; k++) begin
            rd(7'(k), r);
            chk_word(r, 32'h0, "reset value");
        end
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk_bit(e, 1'b1, "unmapped");
        apb(1'b1, 8'h06, 32'h0, r, e);
        chk_bit(e, 1'b1, "unaligned");
        // serial write, then three-wire and four-wire read back
        v = 32'h4 | ($urandom & 32'h3);
        adp_host_model_inst.xfer(1'b0, IDX_IRQM, v[23:0], 1'b0, q);
        rd(IDX_IRQM, r);
        chk_word(r, rd_exp(IDX_IRQM, v), "serial write");
        rd(IDX_IRQS, r);
        chk_word(r, 32'h1 << IRQ_SER, "write done");
        chk_bit(irq, exp_irq(r, v), "irq");
        wr(IDX_IRQM, 32'h0);
        repeat (2) @(posedge core_clk);
        chk_bit(irq, 1'b0, "masked irq");
        adp_host_model_inst.xfer(1'b1, IDX_IRQS, 24'h0, 1'b0, q);
        chk_word({8'h0, q}, 32'h1 << IRQ_SER, "three-wire read");
        wr(IDX_IRQM, v);
        adp_host_model_inst.xfer(1'b1, IDX_IRQM, 24'h0, 1'b0, q);
        chk_word({8'h0, q}, rd_exp(IDX_IRQM, v), "3w read");
        wr(IDX_SCFG, 32'h1 << FOUR_WIRE_BIT);
        adp_host_model_inst.xfer(1'b1, IDX_SCFG, 24'h0, 1'b1, q);
        chk_word({8'h0, q}, 32'h1 << FOUR_WIRE_BIT, "4w read");
        chk_word(adp_host_model_inst.bad_q, 0, "idle pin");
        wr(IDX_IRQS, 32'h7);
        repeat (2) @(posedge core_clk);
        chk_bit(irq, 1'b0, "irq cleared");
        // synchronisation
        wait_pin(0, 80, s, l0);
        chk_bit(s, 1'b0, "sync before input");
        rd(IDX_STAT, r);
        chk_bit(r[ST_RUN], 1'b0, "not started");
        sync_input <= 1'b1;
        wait_pin(0, 80, s, l0);
        chk_bit(s, 1'b1, "sync output");
        rd(IDX_STAT, r);
        chk_bit(r[ST_RUN], 1'b1, "started");
        wr(IDX_CTRL, 32'h1 << CTRL_EDGE);
        wait_pin(0, 80, s, l1);
        wait_pin(0, 80, s, l1);
        chk_bit(l1, !l0, "clock edge choice");
        wr(IDX_CTRL, 32'h1 << CTRL_OVR_SYNC);
        wait_pin(1, 80, s, l1);
        chk_bit(s, 1'b1, "sync on overrange pin");
        wr(IDX_CTRL, 32'h1 << CTRL_SYNC_DIS);
        repeat (2) @(posedge core_clk);
        wait_pin(0, 80, s, l1);
        chk_bit(s, 1'b0, "sync disabled");
        // overrange and its interrupt
        wr(IDX_CTRL, 32'h0);
        wr(IDX_IRQS, 32'h7);
        wr(IDX_IRQM, 32'h1 << IRQ_OVR);
        core_overrange <= 1'b1;
        wait_pin(1, 8, s, l1);
        chk_bit(s, 1'b1, "overrange");
        chk_bit(irq, 1'b1, "overrange irq");
        core_overrange <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk_bit(overrange_flag, 1'b0, "overrange gone");
        wr(IDX_IRQS, 32'h1 << IRQ_OVR);
        repeat (2) @(posedge core_clk);
        chk_bit(irq, 1'b0, "overrange cleared");
        // power-down by pin and by register
        core_sample <= 12'($urandom | 32'h1);
        chip_enable <= 1'b0;
        wait_pin(2, 8, s, l1);
        chk_bit(s, 1'b1, "pin power-down");
        repeat (2) @(posedge core_clk);
        chk_word(32'(sample_data_bus), 32'h0, "bus in power-down");
        chip_enable <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk_bit(power_down, 1'b0, "powered up");
        wr(IDX_CTRL, 32'h1 << CTRL_PD);
        wait_pin(2, 8, s, l1);
        chk_bit(s, 1'b1, "register power-down");
        wr(IDX_CTRL, 32'h0);
        // sample words, corners then random
        for (int k = 0; k < 7; k++) begin
            v = k == 0 ? 32'hFFF : k == 1 ? 32'h800 : k == 2 ? 32'h1
                : $urandom;
            core_sample <= v[SAMPLE_W-1:0];
            repeat (8) @(posedge core_clk);
            n = adp_host_model_inst.ecnt_q;
            for (int j = 0; j < 8 && n == adp_host_model_inst.ecnt_q; j++)
                @(posedge core_clk);
            chk_word(32'(adp_host_model_inst.cap_q), v & 32'hFFF,
                "sample");
        end
        // serial reset clears configuration
        wr(IDX_CTRL, 32'hF);
        serial_port_reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        serial_port_reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(IDX_CTRL, r);
        chk_word(r, 32'(CTRL_RST), "control after reset");
        rd(IDX_SCFG, r);
        chk_word(r, 32'h0, "mode after reset");
        summarize();
    end
endmodule
`default_nettype wire
